// [fpc_map.vh]
// Purpose: constants for the fp condition predicate evaluator
// Assumes: apb byte addressing, 32-bit data
// Notes: offsets are byte addresses
`ifndef FPC_MAP_VH
`define FPC_MAP_VH
`define FPC_OFF_CTRL 12'h000
`define FPC_OFF_COND 12'h004
`define FPC_OFF_RES 12'h008
`define FPC_OFF_CNT 12'h00C
`define FPC_CTRL_PRED_LSB 0
`define FPC_CTRL_REGOUT_BIT 8
`define FPC_COND_N_BIT 3
`define FPC_COND_Z_BIT 2
`define FPC_COND_UNORD_BIT 0
`define FPC_RES_TRUE_BIT 0
`define FPC_RES_EXC_BIT 1
`define FPC_RES_INV_BIT 2
`define FPC_RES_SIG_BIT 3
`define FPC_CTRL_RST 32'h0000_0000
`define FPC_COND_RST 32'h0000_0000
`endif
`default_nettype wire

// [fpc_eval.v]
// Purpose: combinational floating-point condition test evaluator
// Assumes: predicate is 6 bits, condition bits from current cc byte
// Notes: bit 4 of predicate selects signaling test
`default_nettype none
module fpc_eval (
    // test select
    input wire [5:0] pred,
    // condition bits
    input wire unordered_operand_flag,
    input wire zero_flag,
    input wire neg_flag,
    // results
    output reg result,
    output reg unordered_branch_exception,
    output reg signaling,
    output reg invalid
);
    reg base;
    reg u;
    reg z;
    reg n;
    always @* begin
        u = unordered_operand_flag;
        z = zero_flag;
        n = neg_flag;
        base = 1'b0;
        // low four bits name the test; complemented bits mean cleared
        case (pred[3:0])
            4'h0: base = 1'b0;
            4'h1: base = z;
            4'h2: base = ~(u | z | n);
            4'h3: base = z | ~(u | n);
            4'h4: base = n & ~(u | z);
            4'h5: base = z | (n & ~u);
            4'h6: base = ~(u | z);
            4'h7: base = ~u;
            4'h8: base = u;
            4'h9: base = u | z;
            4'hA: base = u | ~(n | z);
            4'hB: base = u | z | ~n;
            4'hC: base = u | (n & ~z);
            4'hD: base = u | z | n;
            4'hE: base = ~z;
            4'hF: base = 1'b1;
            default: base = 1'b0;
        endcase
        invalid = pred[5];
        signaling = pred[4] & ~pred[5];
        result = base & ~pred[5];
        unordered_branch_exception = signaling & u;
    end
endmodule // fpc_eval
`default_nettype wire

// [fpc_apb.v]
// Purpose: apb slave register file for the evaluator
// Assumes: one wait state, 32-bit data
// Notes: unmapped reads return zero and raise pslverr
`include "fpc_map.vh"
`default_nettype none
module fpc_apb (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // block side
    output reg [31:0] ctrl_reg,
    output reg [31:0] cond_reg,
    input wire [31:0] res_word,
    input wire [31:0] cnt_word
);
    reg [31:0] rd_next;
    reg hit;
    always @* begin
        hit = 1'b1;
        rd_next = 32'h0000_0000;
        case (paddr)
            `FPC_OFF_CTRL: rd_next = ctrl_reg;
            `FPC_OFF_COND: rd_next = cond_reg;
            `FPC_OFF_RES: rd_next = res_word;
            `FPC_OFF_CNT: rd_next = cnt_word;
            default: hit = 1'b0;
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `FPC_CTRL_RST;
            cond_reg <= `FPC_COND_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // answer one cycle into the access phase
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata <= (psel & penable & ~pready & ~pwrite) ? rd_next : 32'h0000_0000;
            if (psel & penable & pready & pwrite) begin
                if (paddr == `FPC_OFF_CTRL)
                    ctrl_reg <= {23'h00_0000, pwdata[8:0]};
                if (paddr == `FPC_OFF_COND)
                    cond_reg <= {28'h000_0000, pwdata[3:0]};
            end
        end
    end
endmodule // fpc_apb
`default_nettype wire

// [fpc_top.v]
// Purpose: fp condition predicate evaluator with apb access
// Assumes: one clock pclk at 20 MHz, inputs synchronous
// Notes: direct ports give same-cycle result into output flops
//
// How it works
// - 000001 zero set, 001110 zero clear
// - 010010 all clear, 011101 any set
// - 010011/011100 greater-equal pair, signaling
// - 010100/011011 less-than pair, signaling
// - 010101/011010 less-equal pair, signaling
// - 010110/011001 greater-less pair, signaling
// - 010111 ordered, 011000 unordered, signaling
// - report signaling flag with the result
// - 000010/001101 aware greater pair, quiet
// - 000011/001100 aware greater-equal pair, quiet
// - 000100/001011 aware less-than pair, quiet
// - 000101/001010 aware less-equal pair, quiet
// - 000110/001001 aware greater-less pair, quiet
// - 000111/001000 ordered and unordered, quiet
// - 000000 false, 001111 true, quiet
// - 010000 false, 011111 true, signaling
// - 010001 zero set, 011110 zero clear
// - complemented bit means bit must be clear
//
// The register addresses and register access over APB were chosen for this implementation.
`include "fpc_map.vh"
`default_nettype none
module fpc_top (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // sequencer side
    input wire eval_valid,
    input wire [5:0] eval_pred,
    input wire [7:0] cond_byte,
    // results, registered
    output reg eval_done,
    output reg eval_result,
    output reg unordered_branch_exception,
    output reg eval_signaling,
    output reg eval_invalid
);
    wire [31:0] ctrl_reg;
    wire [31:0] cond_reg;
    wire d_res;
    wire d_exc;
    wire d_sig;
    wire d_inv;
    wire r_res;
    wire r_exc;
    wire r_sig;
    wire r_inv;
    reg [15:0] exc_cnt_reg;

    // datapath for the sequencer port, same cycle
    fpc_eval u_direct (
        .pred(eval_pred),
        .unordered_operand_flag(cond_byte[`FPC_COND_UNORD_BIT]),
        .zero_flag(cond_byte[`FPC_COND_Z_BIT]),
        .neg_flag(cond_byte[`FPC_COND_N_BIT]),
        .result(d_res),
        .unordered_branch_exception(d_exc),
        .signaling(d_sig),
        .invalid(d_inv)
    );

    // software-driven copy for register test access
    fpc_eval u_soft (
        .pred(ctrl_reg[5:0]),
        .unordered_operand_flag(cond_reg[`FPC_COND_UNORD_BIT]),
        .zero_flag(cond_reg[`FPC_COND_Z_BIT]),
        .neg_flag(cond_reg[`FPC_COND_N_BIT]),
        .result(r_res),
        .unordered_branch_exception(r_exc),
        .signaling(r_sig),
        .invalid(r_inv)
    );

    fpc_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ctrl_reg(ctrl_reg),
        .cond_reg(cond_reg),
        .res_word({28'h000_0000, r_sig, r_inv, r_exc, r_res}),
        .cnt_word({16'h0000, exc_cnt_reg})
    );

    // outputs captured from the same-cycle evaluation
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eval_done <= 1'b0;
            eval_result <= 1'b0;
            unordered_branch_exception <= 1'b0;
            eval_signaling <= 1'b0;
            eval_invalid <= 1'b0;
            exc_cnt_reg <= 16'h0000;
        end else begin
            eval_done <= eval_valid;
            if (eval_valid) begin
                eval_result <= d_res;
                unordered_branch_exception <= d_exc;
                eval_signaling <= d_sig;
                eval_invalid <= d_inv;
                if (d_exc && exc_cnt_reg != 16'hFFFF)
                    exc_cnt_reg <= exc_cnt_reg + 16'h0001;
            end
        end
    end
endmodule // fpc_top
`default_nettype wire

// [fpc_assertions.sv]
// Purpose: port checks for fpc_top
// Assumes: single pclk domain
// Notes: bound to every fpc_top instance
`default_nettype none
module fpc_assertions (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // sequencer side
    input wire logic eval_valid,
    input wire logic [5:0] eval_pred,
    input wire logic [7:0] cond_byte,
    input wire logic eval_done,
    input wire logic eval_result,
    input wire logic unordered_branch_exception,
    input wire logic eval_signaling,
    input wire logic eval_invalid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire ok = eval_valid && !eval_pred[5];
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    AST_DONE: assert property (eval_valid |=> eval_done) else $error("done missing");
    AST_IDLE: assert property (!eval_valid |=> !eval_done && $stable(eval_result)) else $error("idle change");
    AST_SIG: assert property (eval_valid |=> eval_signaling == ($past(eval_pred[5:4]) == 2'b01))
        else $error("signaling wrong");
    AST_EXC: assert property (eval_valid |=> unordered_branch_exception ==
        ($past(eval_pred[5:4]) == 2'b01 && $past(cond_byte[0]))) else $error("exception wrong");
    AST_INV: assert property (eval_valid |=> eval_invalid == $past(eval_pred[5]) && !(eval_invalid && eval_result))
        else $error("invalid wrong");
    AST_FALSE: assert property (ok && eval_pred[3:0] == 4'h0 |=> !eval_result) else $error("false test");
    AST_TRUE: assert property (ok && eval_pred[3:0] == 4'hf |=> eval_result) else $error("true test");
    AST_EQ: assert property (ok && eval_pred[3:0] == 4'h1 |=> eval_result == $past(cond_byte[2]))
        else $error("equal test");
    AST_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready) else $error("apb wait");
endmodule // fpc_assertions
bind fpc_top fpc_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .eval_valid(eval_valid), .eval_pred(eval_pred), .cond_byte(cond_byte), .eval_done(eval_done),
    .eval_result(eval_result), .unordered_branch_exception(unordered_branch_exception),
    .eval_signaling(eval_signaling), .eval_invalid(eval_invalid));
`default_nettype wire

// [fpc_seq_model.sv]
// Purpose: sequencer and fp status side driving the test port
// Assumes: idx is {unordered, zero, negative}
// Notes: unused cc bits toggle so they are never trusted
`default_nettype none
module fpc_seq_model (
    input wire logic go,
    input wire logic [5:0] rq_pred,
    input wire logic [2:0] rq_idx,
    output logic eval_valid,
    output logic [5:0] eval_pred,
    output logic [7:0] cond_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    assign eval_valid = go;
    assign eval_pred = rq_pred;
    assign cond_byte = {~rq_pred[3:0], rq_idx[0], rq_idx[1], ~rq_pred[0], rq_idx[2]};
endmodule // fpc_seq_model
`default_nettype wire

// [fp_condition_predicate_eval_tb_top.sv]
// Purpose: self-checking bench for fpc_top
// Assumes: truth rows indexed by {unordered, zero, negative}
// Notes: apb outputs are flops, read in the active region of the edge
`include "fpc_map.vh"
`default_nettype none
module fp_condition_predicate_eval_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, ev, done, res, exc, sig, inv, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [5:0] rq_pred, ep;
    logic [2:0] rq_idx;
    logic [7:0] cb;
    int err_count, n_compared;
    logic [7:0] tt [16] = '{8'h00, 8'hcc, 8'h01, 8'hcd, 8'h02, 8'hce, 8'h03, 8'h0f,
        8'hf0, 8'hfc, 8'hf1, 8'hfd, 8'hf2, 8'hfe, 8'h33, 8'hff};
    fpc_seq_model seq_u (.go(go), .rq_pred(rq_pred), .rq_idx(rq_idx), .eval_valid(ev), .eval_pred(ep), .cond_byte(cb));
    fpc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eval_valid(ev), .eval_pred(ep),
        .cond_byte(cb), .eval_done(done), .eval_result(res), .unordered_branch_exception(exc),
        .eval_signaling(sig), .eval_invalid(inv));
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task tally_and_finish;
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, go, rq_pred, rq_idx} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1 cmp("outs_rst", 0, {done, res, exc, sig, inv});
        apb(0, `FPC_OFF_CTRL, 0);
        cmp("ctrl_rst", `FPC_CTRL_RST, r);
        apb(0, `FPC_OFF_COND, 0);
        cmp("cond_rst", `FPC_COND_RST, r);
        for (int p = 0; p < 64; p++) for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            {go, rq_pred, rq_idx} <= {1'b1, p[5:0], i[2:0]};
            @(posedge pclk);
            #1 cmp("eval", {1'b1, !p[5] & tt[p[3:0]][i], p[5:4] == 2'b01 & i[2], p[5:4] == 2'b01, p[5]},
                {done, res, exc, sig, inv});
        end
        go <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 cmp("hold", 5'h01, {done, res, exc, sig, inv});
        // 64 signaling unordered rows, each presented on two edges
        apb(0, `FPC_OFF_CNT, 0);
        cmp("cnt", 32'h0000_0080, r);
        apb(1, `FPC_OFF_CTRL, 32'h0000_0111);
        apb(1, `FPC_OFF_COND, 32'h0000_0005);
        apb(0, `FPC_OFF_RES, 0);
        cmp("res_seq", 32'h0000_000b, r);
        apb(1, `FPC_OFF_RES, 32'hffff_ffff);
        apb(0, `FPC_OFF_RES, 0);
        cmp("res_ro", 32'h0000_000b, r);
        apb(0, `FPC_OFF_CTRL, 0);
        cmp("ctrl_rd", 32'h0000_0111, r);
        apb(1, `FPC_OFF_CTRL, 32'h0000_0020);
        apb(0, `FPC_OFF_RES, 0);
        cmp("res_inv", 32'h0000_0004, r);
        apb(0, 12'h010, 0);
        cmp("unmapped", 32'h0000_0001, {31'h0000_0000, e});
        cmp("unmapped_data", 0, r);
        {go, rq_pred, rq_idx} <= {1'b1, 6'h0f, 3'h0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b0;
        #1 cmp("mid_rst", 0, {done, res, exc, sig, inv});
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1 cmp("rel_edge", 0, {done, res, exc, sig, inv});
        @(posedge pclk);
        #1 cmp("rel_first", 5'h18, {done, res, exc, sig, inv});
        apb(0, `FPC_OFF_CNT, 0);
        cmp("cnt_rst", 0, r);
        tally_and_finish;
    end
endmodule // fp_condition_predicate_eval_tb_top
`default_nettype wire
